// ---- src/dsa_pkg.sv ----
// shared constants and types of the accumulator add/logic unit
package dsa_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_ACC     = 8'h08;
  localparam logic [7:0] OFS_TEMP0   = 8'h0c;
  localparam logic [7:0] OFS_TEMP1   = 8'h10;
  localparam logic [7:0] OFS_TEMP2   = 8'h14;
  localparam logic [7:0] OFS_OPERAND = 8'h18;
  localparam logic [7:0] OFS_INSTR   = 8'h1c;
  localparam logic [7:0] OFS_LIMM    = 8'h20;
  localparam logic [7:0] OFS_REPEAT  = 8'h24;
  localparam logic [7:0] OFS_TIMING  = 8'h28;
  localparam logic [7:0] OFS_CYCLES  = 8'h2c;
  localparam logic [7:0] OFS_ADDR    = 8'h30;
  localparam logic [2:0] AUX_BANK    = 3'h2;  // paddr[7:5] of the aux bank at 0x40

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SEXT     = 0;
  localparam int CTRL_SATM     = 1;
  localparam int CTRL_TMODE    = 2;
  localparam int CTRL_APTR_LSB = 4;
  localparam int CTRL_PAGE_LSB = 16;
  localparam int ST_CARRY      = 0;
  localparam int ST_OVF        = 1;
  localparam int ST_BUSY       = 2;
  localparam int ST_ERR        = 3;
  localparam int TIM_SAME      = 0;
  localparam int TIM_OPEXT     = 1;
  localparam int TIM_CODEEXT   = 2;
  localparam int TIM_P_LSB     = 8;
  localparam int TIM_D_LSB     = 12;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] ACC_RESET  = 32'h0000_0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [3:0]  WAIT_RESET = 4'h0;

  // ----------------------------------------------------------------
  // opcode patterns and arithmetic limits
  // ----------------------------------------------------------------
  localparam logic [7:0]  OPC_ADD_SHT = 8'h63;
  localparam logic [7:0]  OPC_ADD_UNS = 8'h62;
  localparam logic [7:0]  OPC_ANDM    = 8'h6e;
  localparam logic [7:0]  OPC_AUX_ADD = 8'h78;
  localparam logic [11:0] OPC_ANDL   = 12'hbfb;
  localparam logic [15:0] OPC_ANDL16 = 16'hbe81;
  localparam logic [4:0]  SHIFT_16   = 5'h10;
  localparam logic [31:0] ACC_POS_MAX = 32'h7fff_ffff;
  localparam logic [31:0] ACC_NEG_MAX = 32'h8000_0000;

  // indirect-address update codes in instruction bits 6:4
  localparam logic [2:0] IND_INC   = 3'h1;
  localparam logic [2:0] IND_DEC   = 3'h2;
  localparam logic [2:0] IND_INC0  = 3'h3;
  localparam logic [2:0] IND_DEC0  = 3'h4;
  localparam logic [2:0] IND_BINC0 = 3'h5;
  localparam logic [2:0] IND_BDEC0 = 3'h6;

  // cycle figures
  localparam logic [15:0] CYC_ONE = 16'h0001;
  localparam logic [15:0] CYC_TWO = 16'h0002;

  typedef enum logic {DSA_IDLE, DSA_EXEC} dsa_state_type;
  typedef enum logic [2:0] {OP_NONE, OP_ADD_SHT, OP_ADD_UNS, OP_ANDM, OP_AUX_ADD, OP_ANDL}
    dsa_op_type;

endpackage : dsa_pkg

// ---- src/dsa_acc_adder.sv ----
// shifting 32-bit accumulator adder with carry, overflow and saturation
module dsa_acc_adder
  import dsa_pkg::*;
(
  // operands
  input  wire logic [31:0] acc_in,
  input  wire logic [15:0] operand,
  input  wire logic [3:0]  shift,
  input  wire logic        sign_ext,
  input  wire logic        saturate,
  // result
  output logic      [31:0] sum,
  output logic             carry,
  output logic             overflow
);

  logic [31:0] ext_op;
  logic [31:0] shifted;
  logic [32:0] raw;

  assign ext_op   = sign_ext ? {{16{operand[15]}}, operand} : {16'h0000, operand};
  assign shifted  = ext_op << shift;
  assign raw      = {1'b0, acc_in} + {1'b0, shifted};
  assign carry    = raw[32];
  assign overflow = (acc_in[31] == shifted[31]) && (raw[31] != acc_in[31]);
  assign sum      = (overflow && saturate) ?
                    (acc_in[31] ? ACC_NEG_MAX : ACC_POS_MAX) : raw[31:0];

endmodule : dsa_acc_adder

// ---- src/dsa_core.sv ----
// accumulator add/logic execution unit with APB register access
// Behaviour
// - add_shifted_by_temp shifts the operand left by shift_temp_register[3:0] and add_unsigned_operand it to the accumulator.
// - add_shifted_by_temp sign-extends the operand only when sign_extension_mode is 1.
// - the shifted add sets carry on carry-out, clears it otherwise, and updates overflow_flag.
// - with temp_reg_mode_bit clear a load of primary_temp_register writes all three temp registers.
// - add_shifted_by_temp takes a 7-bit direct offset or indirect addressing with optional new pointer, one word.
// - memory add_unsigned_operand and ANDs take one cycle, two in a shared single_access_ram block, n+1 under repeat.
// - aux_add_immediate add_unsigned_operand its 8-bit constant to the selected auxiliary_register and stores it back.
// - aux_add_immediate is unsigned arithmetic in the aux_reg_arith_unit and changes no status bit.
// - aux_add_immediate cannot be repeated and takes 1 cycle, or 1+p with external code.
// - memory AND combines the operand with accumulator_low_half and zeroes accumulator_high_half.
// - long-immediate AND shifts the zero-extended constant and ANDs it, ignoring sign_extension_mode.
// - long-immediate AND is two words, cannot be repeated, and takes 2 or 2+2p cycles.
// - long-immediate AND has a separate opcode form for a shift of 16.
// - an external operand costs 1+d cycles single and n+nd under repeat.
// - add_unsigned_operand zero-extends the operand regardless of sign_extension_mode.
//
// The APB register port and the register offsets were left to the implementer.
module dsa_core
  import dsa_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    dsa_state_type    st;
    dsa_op_type       op;
    logic             sext;
    logic             satm;
    logic             tmode;
    logic [2:0]       aptr;
    logic [8:0]       page;
    logic             carry;
    logic             ovf;
    logic             err;
    logic [31:0]      acc;
    logic [15:0]      temp0;
    logic [15:0]      temp1;
    logic [15:0]      temp2;
    logic [15:0]      operand;
    logic [15:0]      instr;
    logic [15:0]      limm;
    logic [15:0]      reps;
    logic             same_blk;
    logic             op_ext;
    logic             code_ext;
    logic [3:0]       pw;
    logic [3:0]       dw;
    logic [7:0][15:0] aux;
    logic [15:0]      cycles;
    logic [15:0]      cnt;
    logic [15:0]      iter;
    logic [15:0]      addr;
    logic [31:0]      rdata;
  } dsa_core_state_type;

  dsa_core_state_type s_q;
  dsa_core_state_type s_d;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic dsa_op_type classify(input logic [15:0] w);
    if (w[15:8] == OPC_ADD_SHT) begin
      classify = OP_ADD_SHT;
    end else if (w[15:8] == OPC_ADD_UNS) begin
      classify = OP_ADD_UNS;
    end else if (w[15:8] == OPC_ANDM) begin
      classify = OP_ANDM;
    end else if (w[15:8] == OPC_AUX_ADD) begin
      classify = OP_AUX_ADD;
    end else if (w[15:4] == OPC_ANDL || w == OPC_ANDL16) begin
      classify = OP_ANDL;
    end else begin
      classify = OP_NONE;
    end
  endfunction : classify

  function automatic logic [15:0] cycle_count(input dsa_op_type k, input logic [15:0] n,
                                              input logic same, input logic opx,
                                              input logic cdx, input logic [3:0] p,
                                              input logic [3:0] d);
    logic [15:0] pp;
    logic [15:0] dd;
    pp = {12'h000, p};
    dd = {12'h000, d};
    case (k)
      OP_AUX_ADD: begin
        cycle_count = CYC_ONE + (cdx ? pp : WORD_RESET);
      end
      OP_ANDL: begin
        cycle_count = CYC_TWO + (cdx ? 16'(pp << 1) : WORD_RESET);
      end
      default: begin
        cycle_count = n + (opx ? 16'(n * dd) : WORD_RESET)
                    + ((opx && cdx) ? CYC_ONE : WORD_RESET)
                    + (cdx ? pp : WORD_RESET)
                    + ((same && !opx && !cdx) ? CYC_ONE : WORD_RESET);
      end
    endcase
  endfunction : cycle_count

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  logic        busy;
  logic        acc_wr;
  logic        acc_rd;
  logic        hit;
  logic [31:0] rd_mux;
  logic [31:0] add_sum;
  logic        add_carry;
  logic        add_ovf;
  logic [31:0] and_mask;
  logic [15:0] cur_aux;
  logic [15:0] aux_step;
  logic [15:0] new_aux;
  logic [15:0] n_eff;
  logic        is_rep;
  dsa_op_type  new_op;

  assign busy   = (s_q.st == DSA_EXEC);
  assign pready = !(busy && pwrite);
  assign acc_wr = psel && penable && pwrite && pready;
  assign acc_rd = psel && !penable && !pwrite;
  assign prdata = s_q.rdata;
  assign pslverr = psel && penable && !hit;
  assign n_eff  = (s_q.reps > CYC_ONE) ? s_q.reps : CYC_ONE;
  assign is_rep = (s_q.reps > CYC_ONE);
  assign new_op = classify(pwdata[15:0]);
  assign cur_aux = s_q.aux[s_q.aptr];

  dsa_acc_adder u_adder (
    .acc_in   (s_q.acc),
    .operand  (s_q.operand),
    .shift    ((s_q.op == OP_ADD_SHT) ? s_q.temp1[3:0] : 4'h0),
    .sign_ext ((s_q.op == OP_ADD_SHT) && s_q.sext),
    .saturate (s_q.satm),
    .sum      (add_sum),
    .carry    (add_carry),
    .overflow (add_ovf)
  );

  // long constant, zero-extended both ends, sign mode not consulted
  assign and_mask = (s_q.instr == OPC_ANDL16) ?
                    ({16'h0000, s_q.limm} << SHIFT_16) :
                    ({16'h0000, s_q.limm} << s_q.instr[3:0]);

  // indirect pointer step, unsigned
  always_comb begin
    case (s_q.instr[6:4])
      IND_INC:             aux_step = CYC_ONE;
      IND_DEC:             aux_step = 16'hffff;
      IND_INC0, IND_BINC0: aux_step = s_q.aux[0];
      IND_DEC0, IND_BDEC0: aux_step = 16'(WORD_RESET - s_q.aux[0]);
      default:             aux_step = WORD_RESET;
    endcase
  end
  assign new_aux = 16'(cur_aux + aux_step);

  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    if (paddr[7:5] == AUX_BANK && paddr[1:0] == 2'b00) begin
      rd_mux = {16'h0000, s_q.aux[paddr[4:2]]};
    end else begin
      case (paddr)
        OFS_CTRL: begin
          rd_mux[CTRL_SEXT]  = s_q.sext;
          rd_mux[CTRL_SATM]  = s_q.satm;
          rd_mux[CTRL_TMODE] = s_q.tmode;
          rd_mux[CTRL_APTR_LSB +: 3] = s_q.aptr;
          rd_mux[CTRL_PAGE_LSB +: 9] = s_q.page;
        end
        OFS_STATUS: begin
          rd_mux[ST_CARRY] = s_q.carry;
          rd_mux[ST_OVF]   = s_q.ovf;
          rd_mux[ST_BUSY]  = busy;
          rd_mux[ST_ERR]   = s_q.err;
        end
        OFS_ACC:     rd_mux = s_q.acc;
        OFS_TEMP0:   rd_mux = {16'h0000, s_q.temp0};
        OFS_TEMP1:   rd_mux = {16'h0000, s_q.temp1};
        OFS_TEMP2:   rd_mux = {16'h0000, s_q.temp2};
        OFS_OPERAND: rd_mux = {16'h0000, s_q.operand};
        OFS_INSTR:   rd_mux = {16'h0000, s_q.instr};
        OFS_LIMM:    rd_mux = {16'h0000, s_q.limm};
        OFS_REPEAT:  rd_mux = {16'h0000, s_q.reps};
        OFS_TIMING: begin
          rd_mux[TIM_SAME]    = s_q.same_blk;
          rd_mux[TIM_OPEXT]   = s_q.op_ext;
          rd_mux[TIM_CODEEXT] = s_q.code_ext;
          rd_mux[TIM_P_LSB +: 4] = s_q.pw;
          rd_mux[TIM_D_LSB +: 4] = s_q.dw;
        end
        OFS_CYCLES:  rd_mux = {16'h0000, s_q.cycles};
        OFS_ADDR:    rd_mux = {16'h0000, s_q.addr};
        default:     hit = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (acc_rd) begin
      s_d.rdata = rd_mux;
    end
    // register writes, only while idle (writes stall when busy)
    if (acc_wr && paddr[7:5] == AUX_BANK && paddr[1:0] == 2'b00) begin
      s_d.aux[paddr[4:2]] = pwdata[15:0];
    end else if (acc_wr) begin
      case (paddr)
        OFS_CTRL: begin
          s_d.sext  = pwdata[CTRL_SEXT];
          s_d.satm  = pwdata[CTRL_SATM];
          s_d.tmode = pwdata[CTRL_TMODE];
          s_d.aptr  = pwdata[CTRL_APTR_LSB +: 3];
          s_d.page  = pwdata[CTRL_PAGE_LSB +: 9];
        end
        OFS_STATUS: begin
          s_d.carry = pwdata[ST_CARRY];
          s_d.ovf   = s_q.ovf && !pwdata[ST_OVF];
          s_d.err   = s_q.err && !pwdata[ST_ERR];
        end
        OFS_ACC:   s_d.acc = pwdata;
        OFS_TEMP0: begin
          s_d.temp0 = pwdata[15:0];
          if (!s_q.tmode) begin
            s_d.temp1 = pwdata[15:0];
            s_d.temp2 = pwdata[15:0];
          end
        end
        OFS_TEMP1:   s_d.temp1 = pwdata[15:0];
        OFS_TEMP2:   s_d.temp2 = pwdata[15:0];
        OFS_OPERAND: s_d.operand = pwdata[15:0];
        OFS_LIMM:    s_d.limm = pwdata[15:0];
        OFS_REPEAT:  s_d.reps = pwdata[15:0];
        OFS_TIMING: begin
          s_d.same_blk = pwdata[TIM_SAME];
          s_d.op_ext   = pwdata[TIM_OPEXT];
          s_d.code_ext = pwdata[TIM_CODEEXT];
          s_d.pw       = pwdata[TIM_P_LSB +: 4];
          s_d.dw       = pwdata[TIM_D_LSB +: 4];
        end
        OFS_INSTR: begin
          s_d.instr = pwdata[15:0];
          if (new_op == OP_NONE ||
              (is_rep && (new_op == OP_AUX_ADD || new_op == OP_ANDL))) begin
            s_d.err = 1'b1;
          end else begin
            s_d.op     = new_op;
            s_d.st     = DSA_EXEC;
            s_d.iter   = (new_op == OP_AUX_ADD || new_op == OP_ANDL) ? CYC_ONE : n_eff;
            s_d.cycles = cycle_count(new_op, n_eff, s_q.same_blk, s_q.op_ext,
                                     s_q.code_ext, s_q.pw, s_q.dw);
            s_d.cnt    = s_d.cycles;
          end
        end
        default: begin
        end
      endcase
    end

    // execution: one operation per cycle for the first iter cycles
    if (busy) begin
      s_d.cnt = 16'(s_q.cnt - CYC_ONE);
      if (s_q.cnt <= CYC_ONE) begin
        s_d.st = DSA_IDLE;
      end
      if (s_q.iter != WORD_RESET) begin
        s_d.iter = 16'(s_q.iter - CYC_ONE);
        case (s_q.op)
          OP_ADD_SHT, OP_ADD_UNS: begin
            s_d.acc   = add_sum;
            s_d.carry = add_carry;
            s_d.ovf   = s_q.ovf || add_ovf;
          end
          OP_ANDM: begin
            s_d.acc = {16'h0000, s_q.acc[15:0] & s_q.operand};
          end
          OP_ANDL: begin
            s_d.acc = s_q.acc & and_mask;
          end
          OP_AUX_ADD: begin
            s_d.aux[s_q.aptr] = 16'(cur_aux + {8'h00, s_q.instr[7:0]});
          end
          default: begin
          end
        endcase
        // operand address and indirect pointer update per iteration
        if (s_q.op == OP_ADD_SHT || s_q.op == OP_ADD_UNS || s_q.op == OP_ANDM) begin
          if (!s_q.instr[7]) begin
            s_d.addr = {s_q.page, s_q.instr[6:0]};
          end else begin
            s_d.addr = cur_aux;
            s_d.aux[s_q.aptr] = new_aux;
            if (s_q.instr[3]) begin
              s_d.aptr = s_q.instr[2:0];
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_q          <= '0;
      s_q.st       <= DSA_IDLE;
      s_q.op       <= OP_NONE;
      s_q.acc      <= ACC_RESET;
      s_q.temp0    <= WORD_RESET;
      s_q.temp1    <= WORD_RESET;
      s_q.temp2    <= WORD_RESET;
      s_q.pw       <= WAIT_RESET;
      s_q.dw       <= WAIT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : dsa_core

// ---- verification/dsa_chk.sv ----
// checker of transfer handshake and instruction cycle figures
module dsa_chk
  import dsa_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  logic        acc_w;
  logic        wr_t;
  logic        rd_cyc;
  logic        mapped;
  logic        single;
  logic [15:0] n_v;
  logic [15:0] p_v;
  logic [15:0] rep_q;
  logic [15:0] tim_q;
  logic [15:0] exp_q;
  logic [15:0] exp_d;
  logic [1:0]  kind_q;
  logic [1:0]  kind_d;
  assign acc_w  = psel && penable;
  assign wr_t   = acc_w && pready && pwrite;
  assign rd_cyc = acc_w && pready && !pwrite && paddr == OFS_CYCLES;
  assign mapped = paddr[1:0] == 2'h0 && (paddr <= OFS_ADDR || paddr[7:5] == AUX_BANK);
  assign single = rep_q <= 16'h0001;
  assign n_v    = single ? 16'h0001 : rep_q;
  assign p_v    = tim_q[2] ? {12'h000, tim_q[11:8]} : 16'h0000;
  // ----------------------------------------------------------------
  // expected cycle figure of the last launch
  // ----------------------------------------------------------------
  always_comb begin
    kind_d = kind_q;
    exp_d  = exp_q;
    if (wr_t && paddr == OFS_INSTR) begin
      kind_d = 2'h0;
      if (pwdata[15:8] == OPC_AUX_ADD && single) begin
        kind_d = 2'h1;
        exp_d  = 16'h0001 + p_v;
      end else if ((pwdata[15:4] == OPC_ANDL || pwdata[15:0] == OPC_ANDL16) && single) begin
        kind_d = 2'h2;
        exp_d  = 16'h0002 + (p_v << 1);
      end else if (pwdata[15:8] inside {OPC_ADD_SHT, OPC_ADD_UNS, OPC_ANDM}) begin
        kind_d = 2'h3;
        exp_d  = n_v + (tim_q[1] ? n_v * {12'h000, tim_q[15:12]} : 16'h0000) + p_v
               + {15'h0000, tim_q[1] & tim_q[2]} + {15'h0000, tim_q[0] & ~|tim_q[2:1]};
      end
    end
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rep_q  <= 16'h0000;
      tim_q  <= 16'h0000;
      exp_q  <= 16'h0000;
      kind_q <= 2'h0;
    end else begin
      exp_q  <= exp_d;
      kind_q <= kind_d;
      if (wr_t && paddr == OFS_REPEAT) begin
        rep_q <= pwdata[15:0];
      end
      if (wr_t && paddr == OFS_TIMING) begin
        tim_q <= pwdata[15:0];
      end
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_aux_add_cycles: assert property (rd_cyc && kind_q == 2'h1 |-> prdata[15:0] == exp_q)
    else $error("aux add cycle count wrong");
  a_andl_cycles: assert property (rd_cyc && kind_q == 2'h2 |-> prdata[15:0] == exp_q)
    else $error("long and cycle count wrong");
  a_mem_cycles: assert property (rd_cyc && kind_q == 2'h3 |-> prdata[15:0] == exp_q)
    else $error("memory op cycle count wrong");
  a_read_no_wait: assert property (acc_w && !pwrite |-> pready)
    else $error("read access waited");
  a_stall_bounded: assert property (acc_w && pwrite && !pready |-> ##[1:100] pready)
    else $error("write stall too long");
  a_unmapped_err: assert property (acc_w && !mapped |-> pslverr)
    else $error("unmapped access not flagged");
  a_mapped_ok: assert property (acc_w && mapped |-> !pslverr)
    else $error("mapped access flagged");
  a_err_in_access: assert property (pslverr |-> acc_w)
    else $error("error outside access phase");
  a_unmapped_zero: assert property (acc_w && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  c_aux_add: cover property (rd_cyc && kind_q == 2'h1);
  c_stall: cover property (acc_w && pwrite && !pready);
  c_unmapped: cover property (acc_w && !mapped);
endmodule : dsa_chk

// ---- verification/dsp_accumulator_add_and_logic_test.sv ----
// self-checking bench of the accumulator unit over its register bus
module dsp_accumulator_add_and_logic_test
  import dsa_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rdat;
  logic        errq;
  int          num_errors  = 0;
  int          checks_done = 0;
  always #20 clk_sys = ~clk_sys;
  dsa_core DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  task automatic end_sim();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 300);
    rdat = prdata;
    errq = pslverr;
    if (k >= 300) cmp({31'h0, pready}, 32'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(rdat, e);
  endtask : chk
  task automatic run(input logic [15:0] op);
    int k;
    wr(OFS_INSTR, {16'h0000, op});
    k = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      k++;
    end while (rdat[ST_BUSY] !== 1'b0 && k < 50);
    if (k >= 50) cmp({31'h0, rdat[ST_BUSY]}, 32'h0);
  endtask : run
  initial begin
    #400000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    chk(OFS_ACC, ACC_RESET);
    chk(OFS_STATUS, 32'h0);
    wr(OFS_CTRL, 32'h0004_0004);
    wr(OFS_TEMP1, 32'hff94);
    wr(OFS_OPERAND, 32'h9);
    wr(OFS_ACC, 32'hf715);
    run(16'h637f);
    chk(OFS_ACC, 32'hf7a5);
    chk(OFS_ADDR, 32'h027f);
    chk(OFS_CYCLES, 32'h1);
    chk(OFS_STATUS, 32'h0);
    wr(OFS_TEMP1, 32'hf);
    wr(OFS_OPERAND, 32'h8000);
    wr(OFS_CTRL, 32'h5);
    wr(OFS_ACC, 32'h4000_0000);
    run(16'h6300);
    chk(OFS_ACC, 32'h0);
    chk(OFS_STATUS, 32'h1);
    wr(OFS_CTRL, 32'h4);
    wr(OFS_ACC, 32'h4000_0000);
    run(16'h6300);
    chk(OFS_ACC, 32'h8000_0000);
    chk(OFS_STATUS, 32'h2);
    wr(OFS_STATUS, 32'h2);
    wr(OFS_CTRL, 32'h6);
    wr(OFS_ACC, 32'h4000_0000);
    run(16'h6300);
    chk(OFS_ACC, 32'h7fff_ffff);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_TEMP0, 32'h3);
    chk(OFS_TEMP1, 32'h3);
    chk(OFS_TEMP2, 32'h3);
    wr(OFS_OPERAND, 32'h1);
    wr(OFS_ACC, 32'h0);
    run(16'h6300);
    chk(OFS_ACC, 32'h8);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_OPERAND, 32'hf006);
    wr(OFS_ACC, 32'h3);
    run(16'h6200);
    chk(OFS_ACC, 32'hf009);
    wr(OFS_OPERAND, 32'hffff);
    wr(OFS_ACC, 32'h7fff_0000);
    run(16'h6200);
    chk(OFS_ACC, 32'h7fff_ffff);
    wr(OFS_CTRL, 32'h4);
    wr(OFS_TEMP1, 32'h0);
    wr(8'h40, 32'h027f);
    wr(OFS_OPERAND, 32'h9);
    wr(OFS_ACC, 32'hf715);
    run(16'h63ac);
    chk(OFS_ACC, 32'hf71e);
    chk(8'h40, 32'h027e);
    chk(OFS_CTRL, 32'h44);
    chk(OFS_ADDR, 32'h027f);
    wr(OFS_CTRL, 32'h54);
    wr(OFS_STATUS, 32'h3);
    wr(8'h54, 32'h4321);
    run(16'h7880);
    chk(8'h54, 32'h43a1);
    chk(OFS_STATUS, 32'h1);
    chk(OFS_CYCLES, 32'h1);
    wr(8'h54, 32'hff80);
    run(16'h78ff);
    chk(8'h54, 32'h007f);
    wr(OFS_TIMING, 32'h0304);
    run(16'h7801);
    chk(OFS_CYCLES, 32'h4);
    run(16'hbfb0);
    chk(OFS_CYCLES, 32'h8);
    wr(OFS_TIMING, 32'h0);
    wr(OFS_REPEAT, 32'h2);
    for (int i = 0; i < 2; i++) begin
      run(i == 0 ? 16'h7801 : 16'hbfb0);
      chk(OFS_STATUS, 32'h9);
      wr(OFS_STATUS, 32'h9);
    end
    chk(8'h54, 32'h0080);
    wr(OFS_REPEAT, 32'h0);
    wr(OFS_ACC, 32'h1234_5678);
    wr(OFS_OPERAND, 32'h00ff);
    run(16'h6e10);
    chk(OFS_ACC, 32'h78);
    wr(OFS_CTRL, 32'h5);
    wr(OFS_LIMM, 32'h00ff);
    wr(OFS_ACC, 32'h1234_5678);
    run(16'hbfb4);
    chk(OFS_ACC, 32'h0670);
    chk(OFS_CYCLES, 32'h2);
    wr(OFS_LIMM, 32'hffff);
    wr(OFS_ACC, 32'hffff_ffff);
    run(16'hbfbf);
    chk(OFS_ACC, 32'h7fff_8000);
    wr(OFS_LIMM, 32'h1234);
    wr(OFS_ACC, 32'hffff_ffff);
    run(16'hbe81);
    chk(OFS_ACC, 32'h1234_0000);
    wr(OFS_CTRL, 32'h4);
    wr(OFS_REPEAT, 32'h3);
    wr(OFS_TIMING, 32'h1);
    wr(8'h40, 32'h0100);
    wr(OFS_OPERAND, 32'h2);
    wr(OFS_ACC, 32'h0);
    run(16'h6290);
    chk(OFS_ACC, 32'h6);
    chk(8'h40, 32'h0103);
    chk(OFS_CYCLES, 32'h4);
    wr(OFS_REPEAT, 32'h1);
    run(16'h6200);
    chk(OFS_CYCLES, 32'h2);
    wr(OFS_TIMING, 32'h2002);
    run(16'h6200);
    chk(OFS_CYCLES, 32'h3);
    wr(OFS_REPEAT, 32'h3);
    wr(OFS_INSTR, 32'h6200);
    wr(OFS_LIMM, 32'h0);
    chk(OFS_CYCLES, 32'h9);
    chk(OFS_ACC, 32'h10);
    apb(1'b0, 8'h34, 32'h0);
    cmp({31'h0, errq}, 32'h1);
    cmp(rdat, 32'h0);
    apb(1'b1, 8'h02, 32'h5);
    cmp({31'h0, errq}, 32'h1);
    end_sim();
  end
endmodule : dsp_accumulator_add_and_logic_test
bind dsa_core dsa_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));
